// ### design/tts_pkg.sv
// Behaviour
// - rebuild v5 parity bits after n2 rewrite
// - compensation carries previous frame's altered parity
// - sink compensates v5 after overwriting n2
// - tandem parity mismatch gives near errored block
// - vc parity mismatch gives outgoing errored block
// - recover trace frames 9-72, present accepted
// - extract incoming alarm bit each frame
// - n2 bit5 far errors, frame73 remote defect
// - n2 bit6 outgoing errors, frame74 outgoing defect
// - search alignment word, keep checking position
// - two errored alignment words enter out-of-multiframe
// - one clean alignment word enters in-multiframe
// - overwrite outgoing n2 with zeros
// - five zero n2 frames raise unequipped
// - five nonzero n2 frames clear unequipped
// - loss defect follows out-of-multiframe state
// - trace mismatch settles within one second
// - mismatch held off during server signal fail
// - control disables mismatch detection
// - degrade from near errored block counts
// - alignment word sits in frames 1-8
// - incoming alarm defect five-frame persistence
// - all-ones insertion within 1 ms
// - per-second error counts and defect seconds
package tts_pkg;
  localparam logic [8:0]  VC_FRAME_LEN   = 9'h1ac;
  localparam logic [8:0]  VC_N2_POS      = 9'h0d6;
  localparam logic [6:0]  MF_LEN         = 7'h4c;
  localparam logic [6:0]  MF_FAS_LAST    = 7'h08;
  localparam logic [6:0]  MF_TRACE_FIRST = 7'h09;
  localparam logic [6:0]  MF_TRACE_LAST  = 7'h48;
  localparam logic [6:0]  MF_RDI_FRAME   = 7'h49;
  localparam logic [6:0]  MF_ODI_FRAME   = 7'h4a;
  localparam logic [15:0] MF_ALIGN_WORD  = 16'hfffe;
  localparam logic [2:0]  PERSIST_FRAMES = 3'h5;
  localparam logic [1:0]  TRACE_ACCEPT   = 2'h3;
  localparam int          TRACE_BITS     = 128;
  localparam int          CNT_W          = 16;
  localparam int          BIT_INC_AIS    = 4;
  localparam int          BIT_REI        = 3;
  localparam int          BIT_OEI        = 2;
  localparam int          BIT_ODI        = 1;
  localparam int          BIT_RDI        = 0;

  typedef enum logic {MF_OOM = 1'b0, MF_IM = 1'b1} tts_mf_state_e;

  typedef struct packed {
    logic unequipped;
    logic loss;
    logic incoming_alarm;
    logic remote_defect;
    logic outgoing_defect;
    logic ssf;
  } tts_link_stat_s;

  typedef struct packed {
    logic tandem_unequipped_defect;
    logic tandem_loss_defect;
    logic trace_mismatch_defect;
    logic signal_degrade_defect;
    logic incoming_alarm_defect;
    logic remote_defect;
    logic outgoing_defect;
  } tts_defect_s;

  typedef struct packed {
    logic rdi;
    logic rei;
    logic odi;
    logic oei;
  } tts_ri_s;

  typedef struct packed {
    logic [CNT_W-1:0] near_cnt;
    logic [CNT_W-1:0] far_cnt;
    logic [CNT_W-1:0] onear_cnt;
    logic [CNT_W-1:0] ofar_cnt;
    logic             near_ds;
    logic             far_ds;
    logic             onear_ds;
    logic             ofar_ds;
  } tts_pm_s;
endpackage

// ### design/tts_tandem_trail_sink.sv
`timescale 1ns/1ps
module tts_tandem_trail_sink
  import tts_pkg::*;
#(
  parameter logic [8:0] FRAME_LEN = VC_FRAME_LEN,
  parameter logic [8:0] N2_POS    = VC_N2_POS,
  parameter int         TR_W      = TRACE_BITS
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              link_clk_in,
  input  wire logic [7:0]        link_data_in,
  input  wire logic              link_fs_in,
  input  wire logic              server_signal_fail_in,
  input  wire logic [TR_W-1:0]   expected_trace_in,
  input  wire logic              mismatch_detect_disable_in,
  input  wire logic [3:0]        degrade_monitor_window_in,
  input  wire logic [CNT_W-1:0]  degrade_threshold_in,
  input  wire logic              one_second_in,
  output logic [7:0]             link_data_out,
  output logic                   link_fs_out,
  output logic [TR_W-1:0]        accepted_trace_out,
  output tts_defect_s            defects_out,
  output tts_ri_s                remote_info_out,
  output tts_pm_s                pm_out,
  output logic                   all_ones_request_out
);

  function automatic logic [1:0] fold(input logic [7:0] b);
    fold = {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
  endfunction

  function automatic logic [2:0] persist(input logic [2:0] c, input logic differ);
    persist = differ ? c + 3'h1 : 3'h0;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c, input logic ev);
    sat_inc = (ev && c != '1) ? c + 1'b1 : c;
  endfunction

  // ----------------------------------------------------------------
  // link clock domain: reset, byte position
  // ----------------------------------------------------------------
  logic lrst_m;
  logic lrst;
  always_ff @(posedge link_clk_in)
  begin
    lrst_m <= srst_in;
    lrst   <= lrst_m;
  end

  logic [8:0] pos;
  logic       framed;
  logic       pv;
  logic       is_n2;
  assign is_n2 = framed && !link_fs_in && pos == N2_POS;

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      pos    <= 9'h000;
      framed <= 1'b0;
      pv     <= 1'b0;
    end
    else if (link_fs_in)
    begin
      pos    <= 9'h001;
      framed <= 1'b1;
      pv     <= framed;
    end
    else if (pos != FRAME_LEN - 9'h001)
      pos <= pos + 9'h001;
  end

  // ----------------------------------------------------------------
  // parity checks
  // ----------------------------------------------------------------
  logic [1:0] acc;
  logic [1:0] prev_par;
  logic [3:0] tog;
  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      acc      <= 2'h0;
      prev_par <= 2'h0;
    end
    else if (link_fs_in)
    begin
      acc      <= fold(link_data_in);
      prev_par <= acc;
    end
    else
      acc <= acc ^ fold(link_data_in);
  end

  // toggles: 0 near, 1 far, 2 outgoing near, 3 outgoing far
  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
      tog <= 4'h0;
    else
    begin
      if (is_n2 && pv && link_data_in[7:6] != prev_par)
        tog[0] <= ~tog[0];
      if (is_n2 && link_data_in[BIT_REI])
        tog[1] <= ~tog[1];
      if (link_fs_in && pv && link_data_in[7:6] != acc)
        tog[2] <= ~tog[2];
      if (is_n2 && link_data_in[BIT_OEI])
        tog[3] <= ~tog[3];
    end
  end

  // ----------------------------------------------------------------
  // n2 termination and v5 compensation
  // ----------------------------------------------------------------
  logic       ais_m;
  logic       ais_l;
  logic [1:0] v5i_prev;
  logic [1:0] v5o_prev;
  logic [1:0] n2i_prev;
  logic [1:0] n2o_prev;
  logic [1:0] comp;
  logic [7:0] next_out;

  // previous frame's rewritten v5 bits feed back, so earlier fixes are not lost
  assign comp = pv ? (v5i_prev ^ v5o_prev ^ n2i_prev ^ n2o_prev ^ link_data_in[7:6])
                   : link_data_in[7:6];

  always_comb
  begin
    if (ais_l)
      next_out = 8'hff;
    else if (link_fs_in)
      next_out = {comp, link_data_in[5:0]};
    else if (is_n2)
      next_out = 8'h00;
    else
      next_out = link_data_in;
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      v5i_prev <= 2'h0;
      v5o_prev <= 2'h0;
      n2i_prev <= 2'h0;
      n2o_prev <= 2'h0;
    end
    else if (link_fs_in)
    begin
      v5i_prev <= link_data_in[7:6];
      v5o_prev <= next_out[7:6];
    end
    else if (is_n2)
    begin
      n2i_prev <= fold(link_data_in);
      n2o_prev <= fold(next_out);
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      link_data_out <= 8'h00;
      link_fs_out   <= 1'b0;
    end
    else
    begin
      link_data_out <= next_out;
      link_fs_out   <= link_fs_in;
    end
  end

  // ----------------------------------------------------------------
  // multiframe alignment
  // ----------------------------------------------------------------
  tts_mf_state_e mf_state;
  logic [6:0]    fcnt;
  logic [6:0]    fnum;
  logic [13:0]   mfsh;
  logic [15:0]   word;
  logic          bad_seen;
  assign fnum = (fcnt == MF_LEN) ? 7'h01 : fcnt + 7'h01;
  assign word = {mfsh, link_data_in[BIT_ODI:BIT_RDI]};

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      mf_state <= MF_OOM;
      fcnt     <= 7'h01;
      mfsh     <= 14'h0000;
      bad_seen <= 1'b0;
    end
    else if (is_n2)
    begin
      mfsh <= word[13:0];
      case (mf_state)
        MF_OOM:
        begin
          if (word == MF_ALIGN_WORD)
          begin
            mf_state <= MF_IM;
            fcnt     <= MF_FAS_LAST;
            bad_seen <= 1'b0;
          end
        end
        MF_IM:
        begin
          fcnt <= fnum;
          if (fnum == MF_FAS_LAST)
          begin
            if (word == MF_ALIGN_WORD)
              bad_seen <= 1'b0;
            else if (bad_seen)
              mf_state <= MF_OOM;
            else
              bad_seen <= 1'b1;
          end
        end
        default:
          mf_state <= MF_OOM;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trace recovery and remote indications
  // ----------------------------------------------------------------
  logic [TR_W-1:0] tr_sh;
  logic [TR_W-1:0] rx_last;
  logic [TR_W-1:0] acc_trace;
  logic [TR_W-1:0] rx_now;
  logic [1:0]      same;
  logic            trt;
  logic            rdi_l;
  logic            odi_l;
  logic            in_im;
  assign in_im  = is_n2 && mf_state == MF_IM;
  assign rx_now = {tr_sh[TR_W-3:0], link_data_in[BIT_ODI:BIT_RDI]};

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      tr_sh     <= '0;
      rx_last   <= '0;
      acc_trace <= '0;
      same      <= 2'h0;
      trt       <= 1'b0;
    end
    else if (in_im && fnum >= MF_TRACE_FIRST && fnum <= MF_TRACE_LAST)
    begin
      tr_sh <= rx_now;
      if (fnum == MF_TRACE_LAST)
      begin
        rx_last <= rx_now;
        // a trace is accepted only on its third identical receipt, so one hit cannot flip it
        if (rx_now != rx_last)
          same <= 2'h1;
        else if (same != TRACE_ACCEPT)
          same <= same + 2'h1;
        if (rx_now == rx_last && same == TRACE_ACCEPT - 2'h1 && rx_now != acc_trace)
        begin
          acc_trace <= rx_now;
          trt       <= ~trt;
        end
      end
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      rdi_l <= 1'b0;
      odi_l <= 1'b0;
    end
    else if (in_im)
    begin
      if (fnum == MF_RDI_FRAME)
        rdi_l <= link_data_in[BIT_RDI];
      if (fnum == MF_ODI_FRAME)
        odi_l <= link_data_in[BIT_ODI];
    end
  end

  // ----------------------------------------------------------------
  // unequipped and incoming alarm persistence
  // ----------------------------------------------------------------
  logic [2:0] ucnt;
  logic [2:0] acnt;
  logic       uneq_l;
  logic       inc_l;
  logic       u_diff;
  logic       a_diff;
  assign u_diff = (link_data_in == 8'h00) != uneq_l;
  assign a_diff = link_data_in[BIT_INC_AIS] != inc_l;

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      ucnt   <= 3'h0;
      uneq_l <= 1'b0;
    end
    else if (is_n2)
    begin
      if (u_diff && ucnt == PERSIST_FRAMES - 3'h1)
      begin
        uneq_l <= ~uneq_l;
        ucnt   <= 3'h0;
      end
      else
        ucnt <= persist(ucnt, u_diff);
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      acnt  <= 3'h0;
      inc_l <= 1'b0;
    end
    else if (is_n2)
    begin
      if (a_diff && acnt == PERSIST_FRAMES - 3'h1)
      begin
        inc_l <= ~inc_l;
        acnt  <= 3'h0;
      end
      else
        acnt <= persist(acnt, a_diff);
    end
  end

  tts_link_stat_s lstat;
  assign lstat = '{unequipped: uneq_l, loss: mf_state == MF_OOM, incoming_alarm: inc_l,
                   remote_defect: rdi_l, outgoing_defect: odi_l, ssf: server_signal_fail_in};

  // ----------------------------------------------------------------
  // crossings into the management clock
  // ----------------------------------------------------------------
  tts_link_stat_s stat_m;
  tts_link_stat_s st;
  logic [3:0]     tog_m;
  logic [3:0]     tog_s;
  logic [3:0]     tog_d;
  logic [2:0]     trt_s;
  logic [3:0]     ev;
  assign ev = tog_s ^ tog_d;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      stat_m <= '0;
      st     <= '0;
      tog_m  <= 4'h0;
      tog_s  <= 4'h0;
      tog_d  <= 4'h0;
      trt_s  <= 3'h0;
    end
    else
    begin
      stat_m <= lstat;
      st     <= stat_m;
      tog_m  <= tog;
      tog_s  <= tog_m;
      tog_d  <= tog_s;
      trt_s  <= {trt_s[1:0], trt};
    end
  end

  // acc_trace only changes multiframes apart, so it is stable when sampled
  logic tr_valid;
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      accepted_trace_out <= '0;
      tr_valid           <= 1'b0;
    end
    else if (trt_s[2] != trt_s[1])
    begin
      accepted_trace_out <= acc_trace;
      tr_valid           <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mismatch, degrade, consequent actions
  // ----------------------------------------------------------------
  logic             tim;
  logic             deg;
  logic             tsf;
  logic [CNT_W-1:0] deg_cnt;
  logic [3:0]       bad_run;
  logic             bad_sec;
  assign tsf     = st.ssf | st.unequipped | tim | st.loss;
  assign bad_sec = sat_inc(deg_cnt, ev[0]) >= degrade_threshold_in;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      tim <= 1'b0;
    else
      tim <= !mismatch_detect_disable_in && !st.ssf && tr_valid
             && accepted_trace_out != expected_trace_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      deg_cnt <= '0;
      bad_run <= 4'h0;
      deg     <= 1'b0;
    end
    else if (one_second_in)
    begin
      deg_cnt <= '0;
      bad_run <= bad_sec ? ((bad_run != 4'hf) ? bad_run + 4'h1 : bad_run) : 4'h0;
      if (!bad_sec)
        deg <= 1'b0;
      else if (bad_run + 4'h1 >= degrade_monitor_window_in)
        deg <= 1'b1;
    end
    else
      deg_cnt <= sat_inc(deg_cnt, ev[0]);
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      all_ones_request_out <= 1'b0;
      remote_info_out      <= '0;
    end
    else
    begin
      all_ones_request_out <= st.unequipped | tim | st.loss;
      remote_info_out.rdi  <= tsf;
      remote_info_out.odi  <= tsf | st.incoming_alarm;
      remote_info_out.rei  <= ev[0];
      remote_info_out.oei  <= ev[2];
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst)
    begin
      ais_m <= 1'b0;
      ais_l <= 1'b0;
    end
    else
    begin
      ais_m <= all_ones_request_out;
      ais_l <= ais_m;
    end
  end

  assign defects_out = '{tandem_unequipped_defect: st.unequipped, tandem_loss_defect: st.loss,
                         trace_mismatch_defect: tim, signal_degrade_defect: deg,
                         incoming_alarm_defect: st.incoming_alarm, remote_defect: st.remote_defect,
                         outgoing_defect: st.outgoing_defect};

  // ----------------------------------------------------------------
  // one-second performance counts
  // ----------------------------------------------------------------
  tts_pm_s run;
  logic [3:0] ds_now;
  assign ds_now = {tsf, st.remote_defect, tsf | st.incoming_alarm, st.outgoing_defect};

  // an event landing on the second boundary goes into the closing second
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      run    <= '0;
      pm_out <= '0;
    end
    else if (one_second_in)
    begin
      pm_out.near_cnt  <= sat_inc(run.near_cnt, ev[0]);
      pm_out.far_cnt   <= sat_inc(run.far_cnt, ev[1]);
      pm_out.onear_cnt <= sat_inc(run.onear_cnt, ev[2]);
      pm_out.ofar_cnt  <= sat_inc(run.ofar_cnt, ev[3]);
      {pm_out.near_ds, pm_out.far_ds, pm_out.onear_ds, pm_out.ofar_ds}
        <= {run.near_ds, run.far_ds, run.onear_ds, run.ofar_ds} | ds_now;
      run <= '0;
    end
    else
    begin
      run.near_cnt  <= sat_inc(run.near_cnt, ev[0]);
      run.far_cnt   <= sat_inc(run.far_cnt, ev[1]);
      run.onear_cnt <= sat_inc(run.onear_cnt, ev[2]);
      run.ofar_cnt  <= sat_inc(run.ofar_cnt, ev[3]);
      {run.near_ds, run.far_ds, run.onear_ds, run.ofar_ds}
        <= {run.near_ds, run.far_ds, run.onear_ds, run.ofar_ds} | ds_now;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_n2_zero;
    @(posedge link_clk_in) disable iff (lrst)
    is_n2 && !ais_l |=> link_data_out == 8'h00;
  endproperty
  a_n2_zero: assert property (p_n2_zero) else $error("n2 not zeroed");

  property p_comp;
    @(posedge link_clk_in) disable iff (lrst)
    link_fs_in && pv && !ais_l |=> link_data_out[7:6] ==
      $past(v5i_prev ^ v5o_prev ^ n2i_prev ^ n2o_prev ^ link_data_in[7:6]);
  endproperty
  a_comp: assert property (p_comp) else $error("v5 compensation wrong");

  property p_oom;
    @(posedge link_clk_in) disable iff (lrst)
    in_im && fnum == MF_FAS_LAST && word != MF_ALIGN_WORD && bad_seen |=> mf_state == MF_OOM;
  endproperty
  a_oom: assert property (p_oom) else $error("no out-of-multiframe");

  property p_im;
    @(posedge link_clk_in) disable iff (lrst)
    is_n2 && mf_state == MF_OOM && word == MF_ALIGN_WORD |=> mf_state == MF_IM && fcnt == MF_FAS_LAST;
  endproperty
  a_im: assert property (p_im) else $error("no in-multiframe");

  property p_uneq;
    @(posedge link_clk_in) disable iff (lrst)
    is_n2 && link_data_in == 8'h00 && !uneq_l && ucnt == 3'h4 |=> uneq_l;
  endproperty
  a_uneq: assert property (p_uneq) else $error("unequipped not raised");

  property p_near;
    @(posedge link_clk_in) disable iff (lrst)
    is_n2 && pv && link_data_in[7:6] != prev_par |=> tog[0] != $past(tog[0]);
  endproperty
  a_near: assert property (p_near) else $error("near block missed");

  property p_tim_ssf;
    @(posedge clk_in) disable iff (srst_in)
    st.ssf || mismatch_detect_disable_in |=> !tim;
  endproperty
  a_tim_ssf: assert property (p_tim_ssf) else $error("mismatch not suppressed");

  property p_ais;
    @(posedge clk_in) disable iff (srst_in)
    st.unequipped || st.loss |=> all_ones_request_out ##2 1'b1;
  endproperty
  a_ais: assert property (p_ais) else $error("all-ones request missing");

  c_im: cover property (@(posedge link_clk_in) disable iff (lrst) $rose(mf_state == MF_IM));
  c_uneq: cover property (@(posedge link_clk_in) disable iff (lrst) $rose(uneq_l));
  c_tim: cover property (@(posedge clk_in) disable iff (srst_in) $rose(tim));
  c_near: cover property (@(posedge clk_in) disable iff (srst_in) pm_out.near_cnt != '0);

endmodule // tts_tandem_trail_sink

// ### verif/test_vc2_tandem_trail_sink.sv
`timescale 1ns/1ps
module test_vc2_tandem_trail_sink;
  import tts_pkg::*;
  localparam logic [4:0] C_V5 = 5'h01;
  localparam logic [4:0] C_N2 = 5'h02;
  localparam logic [4:0] C_AL = 5'h04;
  localparam logic [4:0] C_BF = 5'h08;
  localparam logic [4:0] C_ZR = 5'h10;
  logic                  clk_in;
  logic                  srst_in;
  logic                  link_clk_in;
  logic [7:0]            link_data;
  logic                  link_fs;
  logic                  ssf;
  logic [TRACE_BITS-1:0] exp_trace;
  logic                  tim_dis;
  logic                  one_sec;
  logic [7:0]            payload;
  logic [4:0]            ctl;
  logic [7:0]            data_out;
  logic                  fs_out;
  tts_defect_s           defects;
  tts_ri_s               ri;
  tts_pm_s               pm;
  logic                  ais_req;
  logic                  chk_on = 1'b0;
  logic [1:0]            oacc = 2'h0;
  logic [8:0]            opos = 9'h0;
  int                    seed = 29337;
  int                    mismatches = 0;
  int                    compares = 0;
  int                    fcnt = 0;
  int                    rei_n = 0;
  int                    oei_n = 0;
  int                    chk_n = 0;
  int                    n;
  int                    m;

  tts_tandem_trail_sink i_tts_tandem_trail_sink (
    .clk_in(clk_in), .srst_in(srst_in), .link_clk_in(link_clk_in), .link_data_in(link_data),
    .link_fs_in(link_fs), .server_signal_fail_in(ssf), .expected_trace_in(exp_trace),
    .mismatch_detect_disable_in(tim_dis), .degrade_monitor_window_in(4'h1),
    .degrade_threshold_in(16'hffff), .one_second_in(one_sec), .link_data_out(data_out),
    .link_fs_out(fs_out), .accepted_trace_out(), .defects_out(defects),
    .remote_info_out(ri), .pm_out(pm), .all_ones_request_out(ais_req));

  tts_link_source i_tts_link_source (
    .link_clk_in(link_clk_in), .srst_in(srst_in), .payload_in(payload), .ctl_in(ctl),
    .data_out(link_data), .fs_out(link_fs));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    link_clk_in = 1'b0;
    #3.1;
    forever #6 link_clk_in = ~link_clk_in;
  end

  function automatic logic [1:0] fold(input logic [7:0] b);
    return {^(b & 8'haa), ^(b & 8'h55)};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // holds c for k frames, returns at the start of the last of them
  task automatic send(input logic [4:0] c, input int k);
    ctl = c;
    repeat (k) @(posedge link_fs);
    @(negedge clk_in);
  endtask

  task automatic pulse();
    one_sec = 1'b1;
    @(negedge clk_in);
    one_sec = 1'b0;
  endtask

  // ----
  // observers
  // ----
  always @(posedge link_fs)
    fcnt++;

  always @(posedge clk_in)
  begin
    rei_n += ri.rei;
    oei_n += ri.oei;
  end

  always @(negedge clk_in)
    payload <= $random(seed);

  // outgoing parity must stay consistent after the n2 rewrite
  always @(negedge link_clk_in)
  begin
    if (fs_out)
    begin
      // an injected v5 error must pass through; the source holds its control for the whole frame
      if (chk_n > 2)
        check(data_out[7:6], oacc ^ {i_tts_link_source.ctl[0], 1'b0});
      chk_n = chk_on ? chk_n + 1 : 0;
      oacc  = fold(data_out);
      opos  = 9'h0;
    end
    else
    begin
      opos = opos + 9'h1;
      oacc = oacc ^ fold(data_out);
      if (opos == VC_N2_POS && chk_n > 0)
        check(data_out, 8'h00);
    end
  end

  initial
  begin
    repeat (100000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end

  // ----
  // main sequence
  // ----
  initial
  begin
    {ssf, tim_dis, one_sec, ctl, payload} = '0;
    exp_trace = {4{$random(seed)}};
    srst_in   = 1'b1;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 1'b0;
    send(5'h0, 2);
    check(defects.tandem_loss_defect, 1'b1);
    send(5'h0, 10);
    check(defects.tandem_loss_defect, 1'b0);
    send(C_ZR, 4);
    send(5'h0, 1);
    check(defects.tandem_unequipped_defect, 1'b0);
    send(C_ZR, 5);
    send(5'h0, 1);
    check(defects.tandem_unequipped_defect, 1'b1);
    check(ais_req, 1'b1);
    send(5'h0, 5);
    check(defects.tandem_unequipped_defect, 1'b0);
    check(ais_req, 1'b0);
    chk_on = 1'b1;
    pulse();
    rei_n = 0;
    oei_n = 0;
    n = 1 + ($random(seed) & 3);
    m = 1 + ($random(seed) & 3);
    repeat (n)
    begin
      send(C_N2, 1);
      send(5'h0, 1);
    end
    repeat (m)
    begin
      send(C_V5, 1);
      send(5'h0, 1);
    end
    send(5'h0, 1);
    check(rei_n, n);
    check(oei_n, m);
    pulse();
    repeat (8) @(negedge clk_in);
    check(pm.near_cnt, n);
    check(pm.onear_cnt, m);
    check(pm.far_cnt, 16'h0);
    check(pm.ofar_cnt, 16'h0);
    send(C_AL, 4);
    send(5'h0, 1);
    check(defects.incoming_alarm_defect, 1'b0);
    send(C_AL, 5);
    send(5'h0, 1);
    check(defects.incoming_alarm_defect, 1'b1);
    send(5'h0, 3);
    send(C_AL, 1);
    check(defects.incoming_alarm_defect, 1'b1);
    send(5'h0, 6);
    check(defects.incoming_alarm_defect, 1'b0);
    chk_on  = 1'b0;
    ssf     = 1'b1;
    tim_dis = $random(seed);
    send(5'h0, 1);
    check(defects.trace_mismatch_defect, 1'b0);
    // a single errored word must not drop alignment
    send(C_BF, 90 - fcnt);
    check(defects.tandem_loss_defect, 1'b0);
    send(C_BF, 162 - fcnt);
    check(defects.tandem_loss_defect, 1'b1);
    check(ais_req, 1'b1);
    check(defects.signal_degrade_defect, 1'b0);
    check(ri.rdi, 1'b1);
    check(ri.odi, 1'b1);
    check(defects.remote_defect, 1'b0);
    check(defects.outgoing_defect, 1'b0);
    finish_test();
  end
endmodule // test_vc2_tandem_trail_sink

// ### verif/tts_link_source.sv
`timescale 1ns/1ps
module tts_link_source
  import tts_pkg::*;
(
  input  wire logic       link_clk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] payload_in,
  input  wire logic [4:0] ctl_in,
  output logic      [7:0] data_out,
  output logic            fs_out
);
  // ctl: zero n2, bad word, alarm, bad n2 parity, bad v5 parity
  logic [8:0]  pos;
  logic [6:0]  mf;
  logic [1:0]  par;
  logic [1:0]  acc;
  logic [4:0]  ctl;
  logic [7:0]  next_byte;
  logic [15:0] multiframe_alignment_word;

  function automatic logic [1:0] fold(input logic [7:0] b);
    return {^(b & 8'haa), ^(b & 8'h55)};
  endfunction

  always_comb
  begin
    multiframe_alignment_word       = MF_ALIGN_WORD ^ {15'h0, ctl[3]};
    next_byte = payload_in;
    if (pos == 9'h0)
      next_byte = {par ^ {ctl[0], 1'b0}, 6'h00};
    if (pos == VC_N2_POS)
      next_byte = ctl[4] ? 8'h00 : {par ^ {ctl[1], 1'b0}, 1'b1, ctl[2], 2'h0,
                  (mf <= MF_FAS_LAST) ? multiframe_alignment_word[5'd16 - {mf[3:0], 1'b0} +: 2] : 2'h0};
  end

  // ----
  // controls latched at frame end so a frame is never mixed
  // ----
  always_ff @(posedge link_clk_in)
  begin
    if (srst_in)
    begin
      pos      <= VC_FRAME_LEN - 9'h8;
      mf       <= MF_LEN;
      par      <= 2'h0;
      acc      <= 2'h0;
      ctl      <= 5'h0;
      data_out <= 8'h00;
      fs_out   <= 1'b0;
    end
    else
    begin
      data_out <= next_byte;
      fs_out   <= (pos == 9'h0);
      acc      <= (pos == VC_FRAME_LEN - 9'h1) ? 2'h0 : acc ^ fold(next_byte);
      if (pos == VC_FRAME_LEN - 9'h1)
      begin
        pos <= 9'h0;
        mf  <= (mf == MF_LEN) ? 7'h1 : mf + 7'h1;
        par <= acc ^ fold(next_byte);
        ctl <= ctl_in;
      end
      else
        pos <= pos + 9'h1;
    end
  end
endmodule // tts_link_source
